// >>> rtl/gpc_apb_slave.sv
`timescale 1ns/1ps
module gpc_apb_slave (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [gpc_pkg::APB_AW-1:0] i_paddr,
  input wire logic [gpc_pkg::APB_DW-1:0] i_pwdata,
  output logic [gpc_pkg::APB_DW-1:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  gpc_regs_if.apb bus
);
  import gpc_pkg::*;

  gpc_apb_state_type state_reg;
  gpc_apb_state_type state_next;
  logic [APB_DW-1:0] prdata_reg;
  logic [APB_DW-1:0] prdata_next;
  logic pready_reg;
  logic pready_next;
  logic pslverr_reg;
  logic pslverr_next;

  assign bus.addr = i_paddr;
  assign bus.wdata = i_pwdata;
  // Write lands on the edge where pready is seen high
  assign bus.wr_en = (state_reg == ST_ANSWER) && i_psel && i_penable &&
    i_pwrite && bus.hit;

  always_comb begin
    state_next = state_reg;
    prdata_next = prdata_reg;
    pready_next = 1'b0;
    pslverr_next = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (i_psel && i_penable) begin
          state_next = ST_ANSWER;
          pready_next = 1'b1;
          pslverr_next = !bus.hit;
          prdata_next = (bus.hit && !i_pwrite) ? bus.rdata : '0;
        end
      end
      ST_ANSWER: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_reg <= ST_IDLE;
      prdata_reg <= '0;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign o_prdata = prdata_reg;
  assign o_pready = pready_reg;
  assign o_pslverr = pslverr_reg;
endmodule

// >>> rtl/gpc_pin_sync.sv
`timescale 1ns/1ps
module gpc_pin_sync #(
  parameter int WIDTH = 2
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_level
);
  import gpc_pkg::*;

  genvar b;
  generate
    for (b = 0; b < WIDTH; b++) begin : g_bit
      logic [SYNC_STAGES-1:0] sh_reg;
      logic [SYNC_STAGES-1:0] sh_next;
      logic lvl_reg;
      logic lvl_next;
      always_comb begin
        sh_next = {sh_reg[SYNC_STAGES-2:0], i_async[b]};
        // Level moves only once stages two and three agree
        lvl_next = (sh_reg[1] == sh_reg[2]) ? sh_reg[2] : lvl_reg;
      end
      always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
          sh_reg <= '0;
          lvl_reg <= 1'b0;
        end else begin
          sh_reg <= sh_next;
          lvl_reg <= lvl_next;
        end
      end
      assign o_level[b] = lvl_reg;
    end
  endgenerate
endmodule

// >>> rtl/gpc_pkg.sv
package gpc_pkg;

  localparam int APB_AW = 12;
  localparam int APB_DW = 32;

  // Register indices and byte addresses
  localparam logic [9:0] IDX_PIN_FIVE = 10'h204;
  localparam logic [9:0] IDX_PIN_SIX = 10'h205;
  localparam logic [9:0] IDX_OVERRIDE = 10'h206;
  localparam logic [11:0] ADDR_PIN_FIVE = {IDX_PIN_FIVE, 2'b00};
  localparam logic [11:0] ADDR_PIN_SIX = {IDX_PIN_SIX, 2'b00};
  localparam logic [11:0] ADDR_OVERRIDE = {IDX_OVERRIDE, 2'b00};

  // Field positions
  localparam int DIR_BIT = 15;
  localparam int PU_BIT = 14;
  localparam int PD_BIT = 13;
  localparam int POL_BIT = 10;
  localparam int LVL_BIT = 6;
  localparam int FN_LSB = 0;
  localparam int FN_W = 5;
  localparam int OVR_BIT = 0;

  // Values after reset
  localparam logic DIR_RST = 1'h1;
  localparam logic PU_RST = 1'h0;
  localparam logic PD_RST = 1'h0;
  localparam logic POL_RST = 1'h0;
  localparam logic LVL_RST = 1'h0;
  localparam logic [4:0] FN_RST = 5'h00;
  localparam logic OVR_RST = 1'h0;

  // Pin five function codes
  localparam logic [4:0] FN_UNUSED = 5'h00;
  localparam logic [4:0] FN_LEVEL = 5'h01;
  localparam logic [4:0] FN_SERIAL_OUT = 5'h02;
  localparam logic [4:0] FN_IRQ = 5'h03;
  localparam logic [4:0] FN_TEMP_SHUT = 5'h04;
  localparam logic [4:0] FN_LOOP2_LOCK = 5'h06;
  localparam logic [4:0] FN_LOOP3_LOCK = 5'h07;
  localparam logic [4:0] FN_FREQ_LOCK = 5'h09;
  localparam logic [4:0] FN_DYN_ACTIVE = 5'h0A;
  localparam logic [4:0] FN_WSEQ_DONE = 5'h0B;
  localparam logic [4:0] FN_NOISE_GATE = 5'h0C;
  localparam logic [4:0] FN_PEAK_OVER = 5'h0D;
  localparam logic [4:0] FN_SATURATION = 5'h0E;
  localparam logic [4:0] FN_THRESHOLD = 5'h0F;
  localparam logic [4:0] FN_LEVEL_LOCK = 5'h10;
  localparam logic [4:0] FN_BUF_ERROR = 5'h11;
  localparam logic [4:0] FN_OP_CLOCK = 5'h12;
  localparam logic [4:0] FN_DMIC_CLOCK = 5'h13;
  localparam logic [4:0] FN_MIC_DETECT = 5'h15;
  localparam logic [4:0] FN_MIC_SHORT = 5'h16;

  localparam int SYNC_STAGES = 3;

  typedef enum logic {
    ST_IDLE,
    ST_ANSWER
  } gpc_apb_state_type;

endpackage

// >>> rtl/gpc_regs_if.sv
`timescale 1ns/1ps
interface gpc_regs_if;
  import gpc_pkg::*;
  logic wr_en;
  logic [APB_AW-1:0] addr;
  logic [APB_DW-1:0] wdata;
  logic [APB_DW-1:0] rdata;
  logic hit;
  modport apb (output wr_en, output addr, output wdata,
    input rdata, input hit);
  modport regs (input wr_en, input addr, input wdata,
    output rdata, output hit);
endinterface

// >>> rtl/gpc_top.sv
// Contract
// - Code 00001 drives level bit onto pin five
// - Level bit read returns sensed pin level
// - Level readback undefined while pin five outputs
// - Five-bit selector picks pin five role
// - Codes 6,7,9,10,11 give lock/activity/done flags
// - Codes 12 to 16 give level-control flags
// - Code 17 buffer error, 18 operating clock
// - Reserved codes have no defined pin behaviour
// - Codes 19,21,22 give mic clock, detect, short
// - Pin five works only with override set
// - Pin six direction bit: 0 output, 1 input
// - Pin six pull-up enable switches pull-up
// - Pin six pull-down enable switches pull-down
// - Pin six polarity inverts the pin signal
`timescale 1ns/1ps
module gpc_top (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [gpc_pkg::APB_AW-1:0] i_paddr,
  input wire logic [gpc_pkg::APB_DW-1:0] i_pwdata,
  output logic [gpc_pkg::APB_DW-1:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_serial_audio_data_out,
  input wire logic i_irq,
  input wire logic i_temp_shutdown,
  input wire logic i_loop2_lock,
  input wire logic i_loop3_lock,
  input wire logic i_frequency_loop_lock,
  input wire logic i_dynamic_range_control_active,
  input wire logic i_write_seq_done,
  input wire logic i_automatic_level_control_noise_gate,
  input wire logic i_automatic_level_control_peak_overload,
  input wire logic i_automatic_level_control_saturation,
  input wire logic i_automatic_level_control_threshold,
  input wire logic i_automatic_level_control_level_lock,
  input wire logic i_buffer_error,
  input wire logic i_operating_clock_output,
  input wire logic i_dmic_clock,
  input wire logic i_mic_detect,
  input wire logic i_mic_short,
  input wire logic i_pin_five_in,
  output logic o_pin_five_out,
  output logic o_pin_five_oe,
  input wire logic i_pin_six_in,
  input wire logic i_pin_six_drive,
  output logic o_pin_six_out,
  output logic o_pin_six_oe,
  output logic o_pin_six_pullup,
  output logic o_pin_six_pulldown,
  output logic o_pin_six_level
);
  import gpc_pkg::*;

  // Register access carrier
  gpc_regs_if bus();

  // Filtered pad levels, bit 0 pin five, bit 1 pin six
  logic [1:0] pin_lvl;

  // Register fields
  logic p5_dir_reg;
  logic p5_dir_next;
  logic p5_pol_reg;
  logic p5_pol_next;
  logic p5_lvl_reg;
  logic p5_lvl_next;
  logic [FN_W-1:0] p5_fn_reg;
  logic [FN_W-1:0] p5_fn_next;
  logic p6_dir_reg;
  logic p6_dir_next;
  logic p6_pu_reg;
  logic p6_pu_next;
  logic p6_pd_reg;
  logic p6_pd_next;
  logic p6_pol_reg;
  logic p6_pol_next;
  logic ovr_reg;
  logic ovr_next;

  // Pin outputs
  logic p5_out_reg;
  logic p5_out_next;
  logic p5_oe_reg;
  logic p5_oe_next;
  logic p6_out_reg;
  logic p6_out_next;
  logic p6_oe_reg;
  logic p6_oe_next;
  logic p6_lvl_reg;
  logic p6_lvl_next;

  // Function mux result
  logic sel_val;
  logic sel_ok;

  // Register bus front end, one wait state
  gpc_apb_slave u_apb (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_psel(i_psel),
    .i_penable(i_penable),
    .i_pwrite(i_pwrite),
    .i_paddr(i_paddr),
    .i_pwdata(i_pwdata),
    .o_prdata(o_prdata),
    .o_pready(o_pready),
    .o_pslverr(o_pslverr),
    .bus(bus.apb)
  );

  // Pad inputs cross into the clock domain
  gpc_pin_sync #(
    .WIDTH(2)
  ) u_sync (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_async({i_pin_six_in, i_pin_five_in}),
    .o_level(pin_lvl)
  );

  // Address decode and readback
  always_comb begin
    bus.hit = 1'b0;
    bus.rdata = '0;
    case (bus.addr)
      ADDR_PIN_FIVE: begin
        bus.hit = 1'b1;
        bus.rdata[DIR_BIT] = p5_dir_reg;
        bus.rdata[POL_BIT] = p5_pol_reg;
        // Sensed level, not the stored drive value
        bus.rdata[LVL_BIT] = pin_lvl[0];
        bus.rdata[FN_LSB +: FN_W] = p5_fn_reg;
      end
      ADDR_PIN_SIX: begin
        bus.hit = 1'b1;
        bus.rdata[DIR_BIT] = p6_dir_reg;
        bus.rdata[PU_BIT] = p6_pu_reg;
        bus.rdata[PD_BIT] = p6_pd_reg;
        bus.rdata[POL_BIT] = p6_pol_reg;
        bus.rdata[LVL_BIT] = pin_lvl[1];
      end
      ADDR_OVERRIDE: begin
        bus.hit = 1'b1;
        bus.rdata[OVR_BIT] = ovr_reg;
      end
      default: begin
        // Unmapped offsets answer with an error
        bus.hit = 1'b0;
      end
    endcase
  end

  // Register writes
  always_comb begin
    p5_dir_next = p5_dir_reg;
    p5_pol_next = p5_pol_reg;
    p5_lvl_next = p5_lvl_reg;
    p5_fn_next = p5_fn_reg;
    p6_dir_next = p6_dir_reg;
    p6_pu_next = p6_pu_reg;
    p6_pd_next = p6_pd_reg;
    p6_pol_next = p6_pol_reg;
    ovr_next = ovr_reg;
    if (bus.wr_en) begin
      case (bus.addr)
        ADDR_PIN_FIVE: begin
          p5_dir_next = bus.wdata[DIR_BIT];
          p5_pol_next = bus.wdata[POL_BIT];
          p5_lvl_next = bus.wdata[LVL_BIT];
          p5_fn_next = bus.wdata[FN_LSB +: FN_W];
        end
        ADDR_PIN_SIX: begin
          p6_dir_next = bus.wdata[DIR_BIT];
          p6_pu_next = bus.wdata[PU_BIT];
          p6_pd_next = bus.wdata[PD_BIT];
          p6_pol_next = bus.wdata[POL_BIT];
        end
        ADDR_OVERRIDE: begin
          ovr_next = bus.wdata[OVR_BIT];
        end
        default: begin
          // Writes to unmapped offsets are dropped
          ovr_next = ovr_reg;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      p5_dir_reg <= DIR_RST;
      p5_pol_reg <= POL_RST;
      p5_lvl_reg <= LVL_RST;
      p5_fn_reg <= FN_RST;
      p6_dir_reg <= DIR_RST;
      p6_pu_reg <= PU_RST;
      p6_pd_reg <= PD_RST;
      p6_pol_reg <= POL_RST;
      ovr_reg <= OVR_RST;
    end else begin
      p5_dir_reg <= p5_dir_next;
      p5_pol_reg <= p5_pol_next;
      p5_lvl_reg <= p5_lvl_next;
      p5_fn_reg <= p5_fn_next;
      p6_dir_reg <= p6_dir_next;
      p6_pu_reg <= p6_pu_next;
      p6_pd_reg <= p6_pd_next;
      p6_pol_reg <= p6_pol_next;
      ovr_reg <= ovr_next;
    end
  end

  // Pin five function mux
  always_comb begin
    sel_ok = 1'b1;
    sel_val = 1'b0;
    case (p5_fn_reg)
      // Static level from the register
      FN_LEVEL: sel_val = p5_lvl_reg;

      // Data, interrupt and status flags
      FN_SERIAL_OUT: sel_val = i_serial_audio_data_out;
      FN_IRQ: sel_val = i_irq;
      FN_TEMP_SHUT: sel_val = i_temp_shutdown;
      FN_LOOP2_LOCK: sel_val = i_loop2_lock;
      FN_LOOP3_LOCK: sel_val = i_loop3_lock;
      FN_FREQ_LOCK: sel_val = i_frequency_loop_lock;
      FN_DYN_ACTIVE: sel_val = i_dynamic_range_control_active;
      FN_WSEQ_DONE: sel_val = i_write_seq_done;

      // Level-control flags
      FN_NOISE_GATE: begin
        sel_val = i_automatic_level_control_noise_gate;
      end
      FN_PEAK_OVER: begin
        sel_val = i_automatic_level_control_peak_overload;
      end
      FN_SATURATION: begin
        sel_val = i_automatic_level_control_saturation;
      end
      FN_THRESHOLD: begin
        sel_val = i_automatic_level_control_threshold;
      end
      FN_LEVEL_LOCK: begin
        sel_val = i_automatic_level_control_level_lock;
      end

      // Clock, buffer and microphone sources
      FN_BUF_ERROR: sel_val = i_buffer_error;
      FN_OP_CLOCK: sel_val = i_operating_clock_output;
      FN_DMIC_CLOCK: sel_val = i_dmic_clock;
      FN_MIC_DETECT: sel_val = i_mic_detect;
      FN_MIC_SHORT: sel_val = i_mic_short;

      default: begin
        // Unused and reserved codes leave the pin undriven
        sel_ok = 1'b0;
        sel_val = 1'b0;
      end
    endcase
  end

  // Pin drive
  always_comb begin
    // Nothing drives pin five without the override
    p5_oe_next = ovr_reg && !p5_dir_reg && sel_ok;
    p5_out_next = p5_oe_next && (sel_val ^ p5_pol_reg);
    // Pin six follows its own direction bit
    p6_oe_next = !p6_dir_reg;
    p6_out_next = i_pin_six_drive ^ p6_pol_reg;
    p6_lvl_next = pin_lvl[1] ^ p6_pol_reg;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      p5_out_reg <= 1'b0;
      p5_oe_reg <= 1'b0;
      p6_out_reg <= 1'b0;
      p6_oe_reg <= 1'b0;
      p6_lvl_reg <= 1'b0;
    end else begin
      p5_out_reg <= p5_out_next;
      p5_oe_reg <= p5_oe_next;
      p6_out_reg <= p6_out_next;
      p6_oe_reg <= p6_oe_next;
      p6_lvl_reg <= p6_lvl_next;
    end
  end

  assign o_pin_five_out = p5_out_reg;
  assign o_pin_five_oe = p5_oe_reg;
  assign o_pin_six_out = p6_out_reg;
  assign o_pin_six_oe = p6_oe_reg;
  assign o_pin_six_pullup = p6_pu_reg;
  assign o_pin_six_pulldown = p6_pd_reg;
  assign o_pin_six_level = p6_lvl_reg;

endmodule

// >>> tb/gpc_checker.sv
`timescale 1ns/1ps
module gpc_checker (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic o_pin_five_out,
  input wire logic o_pin_five_oe,
  input wire logic i_pin_six_drive,
  input wire logic o_pin_six_out,
  input wire logic o_pin_six_oe,
  input wire logic o_pin_six_pullup,
  input wire logic o_pin_six_pulldown
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  pready_pulse_a: assert property (o_pready |=> !o_pready)
    else $error("pready held too long");
  pready_answer_a: assert property
    ((i_psel && i_penable && !o_pready) |=> o_pready)
    else $error("no answer one cycle after access");
  err_with_ready_a: assert property (o_pslverr |-> o_pready)
    else $error("slave error without ready");
  five_off_a: assert property
    (!o_pin_five_oe |-> !o_pin_five_out)
    else $error("pin five driven while disabled");
  five_oe_a: assert property
    ($changed(o_pin_five_oe) |-> $past(o_pready, 2))
    else $error("pin five enable moved without write");
  six_oe_a: assert property
    ($changed(o_pin_six_oe) |-> $past(o_pready, 2))
    else $error("pin six enable moved without write");
  six_pu_a: assert property
    ($changed(o_pin_six_pullup) |-> $past(o_pready))
    else $error("pull-up moved without write");
  six_pd_a: assert property
    ($changed(o_pin_six_pulldown) |-> $past(o_pready))
    else $error("pull-down moved without write");
  six_drive_a: assert property
    (($changed(i_pin_six_drive) && !o_pready && !$past(o_pready))
    |=> $changed(o_pin_six_out))
    else $error("pin six output did not follow drive");
  cover property (o_pready && o_pslverr);
  cover property (o_pin_five_oe && o_pin_five_out);
  cover property ($rose(o_pin_six_oe));
endmodule
bind gpc_top gpc_checker u_gpc_checker (.i_clk, .i_rst_n, .i_psel, .i_penable,
  .o_pready, .o_pslverr, .o_pin_five_out, .o_pin_five_oe, .i_pin_six_drive,
  .o_pin_six_out, .o_pin_six_oe, .o_pin_six_pullup, .o_pin_six_pulldown);

// >>> tb/gpc_top_tb.sv
`timescale 1ns/1ps
module gpc_top_tb;
  import gpc_pkg::*;
  logic i_clk = 0;
  logic i_rst_n = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [17:0] src = 18'h0;
  logic five_in = 0;
  logic six_in = 0;
  logic six_drive = 1;
  logic five_out, five_oe, six_out, six_oe, six_pu, six_pd, six_lvl;
  int failures = 0;
  int samples_checked = 0;
  logic [31:0] r;
  logic e;
  logic [4:0] codes [18] = '{5'h02, 5'h03, 5'h04, 5'h06, 5'h07, 5'h09,
    5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h0E, 5'h0F, 5'h10, 5'h11, 5'h12, 5'h13,
    5'h15, 5'h16};
  logic [4:0] resv [6] = '{5'h00, 5'h05, 5'h08, 5'h14, 5'h17, 5'h1F};
  always #10 i_clk = ~i_clk;
  gpc_top u_gpc_top (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_serial_audio_data_out(src[0]),
    .i_irq(src[1]), .i_temp_shutdown(src[2]), .i_loop2_lock(src[3]),
    .i_loop3_lock(src[4]), .i_frequency_loop_lock(src[5]),
    .i_dynamic_range_control_active(src[6]), .i_write_seq_done(src[7]),
    .i_automatic_level_control_noise_gate(src[8]),
    .i_automatic_level_control_peak_overload(src[9]),
    .i_automatic_level_control_saturation(src[10]),
    .i_automatic_level_control_threshold(src[11]),
    .i_automatic_level_control_level_lock(src[12]),
    .i_buffer_error(src[13]), .i_operating_clock_output(src[14]),
    .i_dmic_clock(src[15]), .i_mic_detect(src[16]), .i_mic_short(src[17]),
    .i_pin_five_in(five_in), .o_pin_five_out(five_out),
    .o_pin_five_oe(five_oe), .i_pin_six_in(six_in),
    .i_pin_six_drive(six_drive), .o_pin_six_out(six_out),
    .o_pin_six_oe(six_oe), .o_pin_six_pullup(six_pu),
    .o_pin_six_pulldown(six_pd), .o_pin_six_level(six_lvl));
  task automatic report_and_stop();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge i_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1;
    do begin
      @(posedge i_clk);
    end while (pready !== 1'h1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  function automatic logic [31:0] f5(logic p, logic l, logic [4:0] fn);
    return {16'h0, 1'h0, 4'h0, p, 3'h0, l, 1'h0, fn};
  endfunction
  initial begin
    tick(2);
    i_rst_n <= 1;
    apb(0, ADDR_PIN_FIVE, 0);
    chk(r, 32'h8000);
    apb(0, ADDR_PIN_SIX, 0);
    chk(r, 32'h8000);
    apb(0, ADDR_OVERRIDE, 0);
    chk(r, 32'h0);
    apb(0, 12'h81C, 0);
    chk({r[30:0], e}, 32'h1);
    apb(1, ADDR_PIN_SIX, 32'h4000);
    tick(2);
    chk({six_oe, six_pu, six_pd}, 32'h6);
    apb(1, ADDR_PIN_SIX, 32'h2400);
    tick(2);
    chk({six_pu, six_pd, six_out}, 32'h2);
    apb(0, ADDR_PIN_SIX, 0);
    chk(r, 32'h2400);
    tick(1);
    six_drive <= 0;
    tick(2);
    chk(six_out, 32'h1);
    apb(1, ADDR_PIN_SIX, 32'h8400);
    six_in <= 1;
    tick(6);
    chk({six_oe, six_lvl}, 32'h0);
    apb(0, ADDR_PIN_SIX, 0);
    chk(r, 32'h8440);
    apb(1, ADDR_PIN_FIVE, f5(0, 1, 5'h01));
    tick(2);
    chk(five_oe, 32'h0);
    apb(1, ADDR_OVERRIDE, 32'h1);
    tick(2);
    chk({five_oe, five_out}, 32'h3);
    apb(1, ADDR_PIN_FIVE, f5(0, 0, 5'h01));
    tick(2);
    chk({five_oe, five_out}, 32'h2);
    apb(1, ADDR_PIN_FIVE, f5(1, 0, 5'h01));
    tick(2);
    chk(five_out, 32'h1);
    for (int i = 0; i < 18; i++) begin
      apb(1, ADDR_PIN_FIVE, f5(0, 0, codes[i]));
      src <= 18'h1 << i;
      tick(3);
      chk({five_oe, five_out}, 32'h3);
      src <= ~(18'h1 << i);
      tick(3);
      chk({five_oe, five_out}, 32'h2);
    end
    for (int i = 0; i < 6; i++) begin
      apb(1, ADDR_PIN_FIVE, f5(0, 1, resv[i]));
      tick(2);
      chk(five_oe, 32'h0);
    end
    apb(1, ADDR_PIN_FIVE, 32'h8000);
    five_in <= 1;
    tick(6);
    apb(0, ADDR_PIN_FIVE, 0);
    chk(r, 32'h8040);
    report_and_stop();
  end
  initial begin
    #100000;
    failures++;
    report_and_stop();
  end
endmodule
